// file: dv/pic_core_model.sv
// Behavioural model of the 8-bit core that takes vectored interrupts
module pic_core_model
    import pic_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic hold_in,
    input wire logic busy_in,
    input wire pic_push_t push_in,
    input wire logic flags_clear_in,
    input wire pic_pc_load_t pc_load_in,
    input wire logic isr_start_in,
    output logic boundary_out,
    output logic [15:0] pc_out,
    output logic [7:0] flags_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] len_reg;
    logic [7:0] run_reg;
    logic [7:0] stack_q[$];

    // Hold models a very long instruction so the bench can post several sources at once
    // boundary at end
    assign boundary_out = (len_reg == 3'h0) && !hold_in && !busy_in;

    // Instruction length counter, frozen while the core is dispatching
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            len_reg <= 3'h1;
        end else if (!busy_in) begin
            len_reg <= (len_reg == 3'h0) ? 3'($urandom_range(4, 0)) : len_reg - 3'h1;
        end
    end

    // Stack, flags and counter follow the dispatch pulses and the return
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_out <= 16'h1234;
            flags_out <= 8'h01;
            run_reg <= 8'h00;
            stack_q.delete();
        end else begin
            if (push_in.valid) stack_q.push_back(push_in.data);
            if (flags_clear_in) flags_out <= 8'h00;
            if (pc_load_in.load) pc_out <= pc_load_in.value;
            // Handler never re-enables, so the stack stays one frame deep
            // no nesting
            if (isr_start_in) run_reg <= 8'h0c;
            else if (run_reg != 8'h00) run_reg <= run_reg - 8'h01;
            if (run_reg == 8'h01) begin
                flags_out <= stack_q.pop_back();
                pc_out[7:0] <= stack_q.pop_back();
                pc_out[15:8] <= stack_q.pop_back();
            end
        end
    end
endmodule : pic_core_model

// file: dv/test_priority_interrupt_controller.sv
// Self-checking testbench of the interrupt controller with a core model
`include "pic_cfg.svh"
module test_priority_interrupt_controller;
    timeunit 1ns;
    timeprecision 100ps;
    import pic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, boundary, irq_active, busy, fclr, isr, rerr;
    logic [25:0] hw_event = 26'h0;
    logic [7:0] g0 = 8'h00, g1 = 8'h00, g2 = 8'h00, flags, rdat;
    logic [15:0] pc;
    logic [23:0] bits;
    pic_push_t push;
    pic_pc_load_t prog_counter_low;
    int miscompares = 0, checks = 0, cyc = 0;

    pic_irq_ctrl i_dut (.sys_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .hw_event_in(hw_event), .gpio0_pins_in(g0), .gpio1_pins_in(g1), .gpio2_pins_in(g2),
        .global_irq_enable_in(flags[0]), .instr_boundary_in(boundary), .pc_in(pc),
        .flags_in(flags), .irq_active_out(irq_active), .dispatch_busy_out(busy),
        .push_out(push), .flags_clear_out(fclr), .pc_load_out(prog_counter_low), .isr_start_out(isr));
    pic_core_model i_core (.sys_clk_in(clk), .arst_n_in(rst_n), .hold_in(hold),
        .busy_in(busy), .push_in(push), .flags_clear_in(fclr), .pc_load_in(prog_counter_low),
        .isr_start_in(isr), .boundary_out(boundary), .pc_out(pc), .flags_out(flags));

    // Clock and a hang guard well above the expected run length
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; an idle cycle follows so psel is never driven twice in a step
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // pready is tied high, so this wait ends at the first access-phase edge
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk("read", rdat, exp);
    endtask : rd

    task automatic pulse(input int s);
        hw_event[s] <= 1'b1;
        @(posedge clk);
        hw_event <= 26'h0;
    endtask : pulse

    // Register bit of a slot as reg*8+bit, or -1 for a reserved slot
    function automatic int loc(input int s);
        case (s)
            1: return 0;
            3: return 2;
            4: return 3;
            5: return 4;
            7: return 5;
            25: return 6;
            6: return 7;
            13, 14, 17, 18, 20: return s;
            default: return -1;
        endcase
    endfunction : loc

    // Follows one dispatch cycle by cycle from the first push
    task automatic disp(input int s);
        int n;
        logic [15:0] pc0;
        logic [7:0] f0;
        n = 0;
        while (push.valid !== 1'b1 && n < 500) begin
            pc0 = pc;
            f0 = flags;
            @(negedge clk);
            n++;
        end
        chk("push_hi", push, {1'b1, pc0[15:8]});
        @(negedge clk);
        chk("push_lo", push, {1'b1, pc0[7:0]});
        @(negedge clk);
        chk("push_flags", push, {1'b1, f0});
        @(negedge clk);
        chk("flags_clear", fclr, 1'b1);
        repeat (9) @(negedge clk);
        chk("vector", prog_counter_low, {1'b1, 8'h00, 8'(s * 4)});
        repeat (7) @(negedge clk);
        chk("isr_start", isr, 1'b1);
        @(negedge clk);
        chk("busy_end", busy, 1'b0);
        // Hand back just after a rising edge so the next driver starts there
        @(posedge clk);
    endtask : disp

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        void'($urandom(32'h34dfba4a));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`PIC_IDX_CLR0, 8'h00);
        apb(1'b0, 10'h0d0, 8'h00);
        chk("unmapped_err", rerr, 1'b1);
        $display("test reset done");
        pulse(4);
        rd(`PIC_IDX_CLR0, 8'h08);
        chk("active", irq_active, 1'b0);
        apb(1'b1, `PIC_IDX_MSK0, 8'h08);
        disp(4);
        rd(`PIC_IDX_CLR0, 8'h00);
        pulse(13);
        rd(`PIC_IDX_CLR1, 8'h20);
        apb(1'b1, `PIC_IDX_CLR1, 8'hdf);
        rd(`PIC_IDX_CLR1, 8'h00);
        $display("test post_clear done");
        g0 <= 8'h08;
        g1 <= 8'h80;
        g2 <= 8'h01;
        hw_event <= 26'h0000005;
        @(posedge clk);
        hw_event <= 26'h0;
        repeat (3) @(posedge clk);
        rd(`PIC_IDX_CLR0, 8'h90);
        rd(`PIC_IDX_CLR2, 8'h10);
        apb(1'b1, `PIC_IDX_CLR0, 8'h6f);
        apb(1'b1, `PIC_IDX_CLR2, 8'hef);
        repeat (4) @(posedge clk);
        rd(`PIC_IDX_CLR0, 8'h00);
        rd(`PIC_IDX_CLR2, 8'h00);
        g0 <= 8'h00;
        g1 <= 8'h00;
        g2 <= 8'h00;
        $display("test gpio done");
        hold <= 1'b1;
        apb(1'b1, `PIC_IDX_MSK3, 8'h80);
        rd(`PIC_IDX_MSK3, 8'h80);
        apb(1'b1, `PIC_IDX_MSK0, 8'hff);
        apb(1'b1, `PIC_IDX_MSK1, 8'hff);
        apb(1'b1, `PIC_IDX_MSK2, 8'hff);
        for (int k = 0; k < 6; k++) begin
            bits = {8'($urandom) & 8'h16, 8'($urandom) & 8'h60, 8'($urandom) & 8'hfd};
            if (k == 0) bits = 24'h1660fd;
            hold <= 1'b1;
            apb(1'b1, `PIC_IDX_CLR0, bits[7:0]);
            apb(1'b1, `PIC_IDX_CLR1, bits[15:8]);
            apb(1'b1, `PIC_IDX_CLR2, bits[23:16]);
            rd(`PIC_IDX_CLR0, bits[7:0]);
            hold <= 1'b0;
            for (int s = 0; s < 26; s++) begin
                if (loc(s) >= 0 && bits[loc(s)]) disp(s);
            end
            rd(`PIC_IDX_CLR2, 8'h00);
        end
        $display("test priority done");
        end_of_test();
    end
endmodule : test_priority_interrupt_controller

// file: hdl/pic_cfg.svh
// Register indices, slot numbers, reset values and timing counts of the interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Register indices; the APB byte address is four times the index
`define PIC_IDX_CLR0 10'h0da
`define PIC_IDX_CLR1 10'h0db
`define PIC_IDX_CLR2 10'h0dc
`define PIC_IDX_MSK3 10'h0de
`define PIC_IDX_MSK2 10'h0df
`define PIC_IDX_MSK0 10'h0e0
`define PIC_IDX_MSK1 10'h0e1
`define PIC_SWPOST_BIT 7

// Priority slots
`define PIC_NUM_SLOTS 26
`define PIC_SLOT_NONE 5'h1f
`define PIC_SLOT_PWR 5'h01
`define PIC_SLOT_SPI_TX 5'h03
`define PIC_SLOT_SPI_RX 5'h04
`define PIC_SLOT_GPIO0 5'h05
`define PIC_SLOT_GPIO1 5'h06
`define PIC_SLOT_EXT_A 5'h07
`define PIC_SLOT_TICK 5'h0d
`define PIC_SLOT_PIT 5'h0e
`define PIC_SLOT_WRAP 5'h11
`define PIC_SLOT_EXT_B 5'h12
`define PIC_SLOT_GPIO2 5'h14
`define PIC_SLOT_SLEEP 5'h19
`define PIC_VALID_SLOTS 26'h21660fa
`define PIC_POSTED_RESET 26'h0000000
`define PIC_MASK_RESET 26'h0000000

// Dispatch timing in CPU cycles
`define PIC_DISPATCH_CYCLES 4'hd
`define PIC_JUMP_CYCLES 4'h7
`define PIC_STEP_PUSH_HI 4'h0
`define PIC_STEP_PUSH_LO 4'h1
`define PIC_STEP_PUSH_FLAGS 4'h2
`define PIC_STEP_FLAG_CLR 4'h3

`endif

// file: hdl/pic_edge_detect.sv
// Rising-edge detector that turns a port's pins into one posting pulse
module pic_edge_detect #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic edge_out
);
    logic [WIDTH-1:0] prev_reg;
    logic edge_reg;

    // Posting follows pin edges, so a held level posts only once
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_reg <= '0;
            edge_reg <= 1'b0;
        end else begin
            prev_reg <= pins_in;
            edge_reg <= |(pins_in & ~prev_reg);
        end
    end

    assign edge_out = edge_reg;
endmodule : pic_edge_detect

// file: hdl/pic_irq_ctrl.sv
// Vectored fixed-priority interrupt controller with dispatch sequencer and APB registers
//
// Functional notes
// - Slots 0 to 25, vector address is four times the slot number.
// - Fixed slot assignment per source; the other slots are reserved.
// - A source condition sets its posted flip-flop.
// - Posted stays until taken or cleared by a clear-register write.
// - Posted counts as pending only while its mask bit is set.
// - Priority encoder picks the best pending; taken only with global enable.
// - Clearing a mask bit neither clears nor blocks posting.
// - Request becomes active by event, mask write, or global enable rising.
// - Dispatch starts only once the current instruction has finished.
// - Dispatch lasts exactly 13 cycles as an automatic call.
// - Dispatch pushes counter high byte, counter low byte, then flags.
// - After the pushes the whole flag register is cleared.
// - Counter high byte becomes zero, low byte takes the vector.
// - Return restores counter and flags, so global enable returns.
// - Pending requests after a return are served before next instruction.
// - Latency is rest of instruction plus 13 plus 7 jump cycles.
// - Interrupts can be disabled globally and per source.
// - Clear-register writes: 0 clears normally; with software post, 1 posts.
// - Reading a clear register shows which sources are posted.
// - GPIO port sources post on pin edges, not levels.
//
// The register addresses and the APB slave port were left to the implementer.
`include "pic_cfg.svh"

module pic_irq_ctrl
    import pic_pkg::*;
#(
    parameter int GPIO_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [`PIC_NUM_SLOTS-1:0] hw_event_in,
    input wire logic [GPIO_W-1:0] gpio0_pins_in,
    input wire logic [GPIO_W-1:0] gpio1_pins_in,
    input wire logic [GPIO_W-1:0] gpio2_pins_in,
    input wire logic global_irq_enable_in,
    input wire logic instr_boundary_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    output logic irq_active_out,
    output logic dispatch_busy_out,
    output pic_push_t push_out,
    output logic flags_clear_out,
    output pic_pc_load_t pc_load_out,
    output logic isr_start_out
);
    localparam logic [25:0] VALID = `PIC_VALID_SLOTS;

    // Slot that sits behind bit b of the byte-wide register view
    function automatic logic [4:0] slot_of(input int b);
        case (b)
            0: slot_of = `PIC_SLOT_PWR;
            2: slot_of = `PIC_SLOT_SPI_TX;
            3: slot_of = `PIC_SLOT_SPI_RX;
            4: slot_of = `PIC_SLOT_GPIO0;
            5: slot_of = `PIC_SLOT_EXT_A;
            6: slot_of = `PIC_SLOT_SLEEP;
            7: slot_of = `PIC_SLOT_GPIO1;
            13: slot_of = `PIC_SLOT_TICK;
            14: slot_of = `PIC_SLOT_PIT;
            17: slot_of = `PIC_SLOT_WRAP;
            18: slot_of = `PIC_SLOT_EXT_B;
            20: slot_of = `PIC_SLOT_GPIO2;
            default: slot_of = `PIC_SLOT_NONE;
        endcase
    endfunction : slot_of

    // Three register bytes to slot vector
    function automatic logic [25:0] from_regs(input logic [23:0] r);
        logic [4:0] sl;
        from_regs = '0;
        for (int b = 0; b < 24; b++) begin
            sl = slot_of(b);
            if (sl != `PIC_SLOT_NONE) begin
                from_regs[sl] = r[b];
            end
        end
    endfunction : from_regs

    // Slot vector to three register bytes; reserved bits read zero
    function automatic logic [23:0] to_regs(input logic [25:0] s);
        logic [4:0] sl;
        to_regs = '0;
        for (int b = 0; b < 24; b++) begin
            sl = slot_of(b);
            if (sl != `PIC_SLOT_NONE) begin
                to_regs[b] = s[sl];
            end
        end
    endfunction : to_regs

    // Byte lane of the register view
    function automatic logic [7:0] byte_of(input logic [23:0] v, input logic [1:0] lane);
        byte_of = v[{lane, 3'b000} +: 8];
    endfunction : byte_of

    logic [25:0] posted_reg;
    logic [25:0] posted_next;
    logic [25:0] mask_reg;
    logic swpost_reg;
    logic [31:0] prdata_reg;
    logic err_reg;
    pic_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [4:0] slot_reg;
    logic [7:0] pc_lo_reg;
    logic [7:0] flags_reg;
    pic_push_t push_reg;
    logic flags_clear_reg;
    pic_pc_load_t pc_load_reg;
    logic isr_start_reg;
    logic [2:0] gpio_edge;
    logic [25:0] hw_set;
    pic_sel_t sel;
    logic take;

    // Address decode; the index is the word address
    logic [9:0] idx;
    logic aligned;
    logic is_clr;
    logic is_msk;
    logic is_msk3;
    logic [1:0] lane;
    always_comb begin
        idx = paddr_in[11:2];
        aligned = (paddr_in[1:0] == 2'b00);
        is_clr = 1'b0;
        is_msk = 1'b0;
        is_msk3 = 1'b0;
        lane = 2'b00;
        case (idx)
            `PIC_IDX_CLR0: is_clr = 1'b1;
            `PIC_IDX_CLR1: begin
                is_clr = 1'b1;
                lane = 2'b01;
            end
            `PIC_IDX_CLR2: begin
                is_clr = 1'b1;
                lane = 2'b10;
            end
            `PIC_IDX_MSK0: is_msk = 1'b1;
            `PIC_IDX_MSK1: begin
                is_msk = 1'b1;
                lane = 2'b01;
            end
            `PIC_IDX_MSK2: begin
                is_msk = 1'b1;
                lane = 2'b10;
            end
            `PIC_IDX_MSK3: is_msk3 = 1'b1;
            default: ;
        endcase
    end

    logic mapped;
    logic wr_en;
    logic clr_wr;
    logic msk_wr;
    logic [25:0] wr_field;
    logic [25:0] wr_val;
    // A write takes effect only at the access-phase edge
    assign mapped = aligned & (is_clr | is_msk | is_msk3);
    assign wr_en = psel_in & penable_in & pwrite_in & mapped;
    assign clr_wr = wr_en & is_clr;
    assign msk_wr = wr_en & is_msk;
    assign wr_field = from_regs(24'h0000ff << {lane, 3'b000});
    assign wr_val = from_regs({16'h0000, pwdata_in[7:0]} << {lane, 3'b000});

    // Read data and error are captured in the setup phase, so pready never waits
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else if (psel_in && !penable_in) begin
            err_reg <= ~mapped;
            prdata_reg <= 32'h00000000;
            if (is_clr && aligned) begin
                prdata_reg[7:0] <= byte_of(to_regs(posted_reg), lane);
            end else if (is_msk && aligned) begin
                prdata_reg[7:0] <= byte_of(to_regs(mask_reg), lane);
            end else if (is_msk3 && aligned) begin
                prdata_reg[`PIC_SWPOST_BIT] <= swpost_reg;
            end
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & err_reg;

    pic_edge_detect #(.WIDTH(GPIO_W)) u_edge0 (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pins_in(gpio0_pins_in),
        .edge_out(gpio_edge[0])
    );
    pic_edge_detect #(.WIDTH(GPIO_W)) u_edge1 (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pins_in(gpio1_pins_in),
        .edge_out(gpio_edge[1])
    );
    pic_edge_detect #(.WIDTH(GPIO_W)) u_edge2 (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pins_in(gpio2_pins_in),
        .edge_out(gpio_edge[2])
    );

    // source to slot wiring; GPIO slots come from pin edges only
    always_comb begin
        hw_set = hw_event_in;
        hw_set[`PIC_SLOT_GPIO0] = gpio_edge[0];
        hw_set[`PIC_SLOT_GPIO1] = gpio_edge[1];
        hw_set[`PIC_SLOT_GPIO2] = gpio_edge[2];
    end

    // Posted next value; the hardware set is applied last so it wins over any clear
    always_comb begin
        posted_next = posted_reg;
        if (pc_load_reg.load) begin
            posted_next[slot_reg] = 1'b0;
        end
        if (clr_wr) begin
            if (swpost_reg) begin
                posted_next = posted_next | (wr_field & wr_val);
            end else begin
                posted_next = posted_next & ~(wr_field & ~wr_val);
            end
        end
        posted_next = posted_next | hw_set;
        posted_next = posted_next & VALID;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            posted_reg <= `PIC_POSTED_RESET;
        end else begin
            posted_reg <= posted_next;
        end
    end

    // mask bits only gate pending, never posting
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_reg <= `PIC_MASK_RESET;
            swpost_reg <= 1'b0;
        end else begin
            if (msk_wr) begin
                mask_reg <= ((mask_reg & ~wr_field) | (wr_val & wr_field)) & VALID;
            end
            if (wr_en && is_msk3) begin
                swpost_reg <= pwdata_in[`PIC_SWPOST_BIT];
            end
        end
    end

    // pending gate, best pending picked, lowest slot wins
    pic_prio_enc #(.N(`PIC_NUM_SLOTS)) u_enc (
        .req_in(posted_reg & mask_reg & VALID),
        .sel_out(sel)
    );

    // active by event, mask write or enable rise, all seen as one level
    // global gate on top of the per-source masks
    assign irq_active_out = sel.valid & global_irq_enable_in;
    // take only at an instruction boundary
    // enable restored by a return lets pending go first
    assign take = (state_reg == pic_st_idle) & instr_boundary_in & irq_active_out;

    // dispatch sequencer, then the table jump
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= pic_st_idle;
            cnt_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                pic_st_idle: begin
                    if (take) begin
                        state_reg <= pic_st_dispatch;
                        cnt_reg <= 4'h0;
                    end
                end
                pic_st_dispatch: begin
                    if (cnt_reg == `PIC_DISPATCH_CYCLES - 4'h1) begin
                        state_reg <= pic_st_jump;
                        cnt_reg <= 4'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                pic_st_jump: begin
                    if (cnt_reg == `PIC_JUMP_CYCLES - 4'h1) begin
                        state_reg <= pic_st_idle;
                        cnt_reg <= 4'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= pic_st_idle;
                    cnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // Snapshot at take; later encoder changes do not redirect this dispatch
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slot_reg <= 5'h00;
            pc_lo_reg <= 8'h00;
            flags_reg <= 8'h00;
        end else if (take) begin
            slot_reg <= sel.slot;
            pc_lo_reg <= pc_in[7:0];
            flags_reg <= flags_in;
        end
    end

    // Core-facing outputs, registered one step ahead of their cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            push_reg <= '0;
            flags_clear_reg <= 1'b0;
            pc_load_reg <= '0;
            isr_start_reg <= 1'b0;
        end else begin
            push_reg <= '0;
            flags_clear_reg <= 1'b0;
            pc_load_reg <= '0;
            isr_start_reg <= 1'b0;
            if (take) begin
                push_reg <= '{valid: 1'b1, data: pc_in[15:8]};
            end else if (state_reg == pic_st_dispatch && cnt_reg == `PIC_STEP_PUSH_HI) begin
                push_reg <= '{valid: 1'b1, data: pc_lo_reg};
            end else if (state_reg == pic_st_dispatch && cnt_reg == `PIC_STEP_PUSH_LO) begin
                push_reg <= '{valid: 1'b1, data: flags_reg};
            end
            if (state_reg == pic_st_dispatch && cnt_reg == `PIC_STEP_PUSH_FLAGS) begin
                flags_clear_reg <= 1'b1;
            end
            // high byte zero, low byte the vector
            // vector is four times the slot
            if (state_reg == pic_st_dispatch && cnt_reg == `PIC_DISPATCH_CYCLES - 4'h2) begin
                pc_load_reg <= '{load: 1'b1, value: {8'h00, 1'b0, slot_reg, 2'b00}};
            end
            if (state_reg == pic_st_jump && cnt_reg == `PIC_JUMP_CYCLES - 4'h2) begin
                isr_start_reg <= 1'b1;
            end
        end
    end

    assign dispatch_busy_out = (state_reg != pic_st_idle);
    assign push_out = push_reg;
    assign flags_clear_out = flags_clear_reg;
    assign pc_load_out = pc_load_reg;
    assign isr_start_out = isr_start_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_vector_value: assert property (
        pc_load_out.load |-> pc_load_out.value == {8'h00, 1'b0, $past(sel.slot, 13), 2'b00})
        else $error("vector is not four times the slot");
    a_reserved_clear: assert property (
        (posted_reg & ~VALID) == 26'h0 && (!sel.valid || VALID[sel.slot]))
        else $error("reserved slot posted or selected");
    a_post_sets: assert property (
        (hw_set & VALID) != 26'h0 |=> (posted_reg & $past(hw_set & VALID)) == $past(hw_set & VALID))
        else $error("source event did not post");
    a_posted_hold: assert property (
        ($past(posted_reg) & ~posted_reg) != 26'h0 |-> $past(clr_wr || pc_load_out.load))
        else $error("posted flag dropped without take or clear");
    a_take_gate: assert property (
        state_reg == pic_st_idle ##1 state_reg == pic_st_dispatch
        |-> $past(global_irq_enable_in && instr_boundary_in && sel.valid))
        else $error("dispatch started without enable or boundary");
    a_dispatch_len: assert property (
        take |=> (state_reg == pic_st_dispatch)[*8] ##1 (state_reg == pic_st_dispatch)[*5]
        ##1 state_reg == pic_st_jump)
        else $error("dispatch not thirteen cycles");
    a_push_order: assert property (
        take |=> push_out.valid && push_out.data == $past(pc_in[15:8])
        ##1 push_out.valid && push_out.data == $past(pc_in[7:0], 2)
        ##1 push_out.valid && push_out.data == $past(flags_in, 3) ##1 !push_out.valid)
        else $error("stack push order wrong");
    a_flags_clear: assert property (
        take |-> ##4 flags_clear_out ##9 pc_load_out.load)
        else $error("flag clear or vector load mistimed");
    a_latency_jump: assert property (
        take |-> ##20 isr_start_out)
        else $error("handler start not twenty cycles after take");
    a_taken_cleared: assert property (
        pc_load_out.load && !hw_set[slot_reg] && !clr_wr |=> !posted_reg[$past(slot_reg)])
        else $error("taken request still posted");
    a_sw_post: assert property (
        clr_wr && swpost_reg |=> (posted_reg & $past(wr_field & wr_val & VALID))
        == $past(wr_field & wr_val & VALID))
        else $error("software post lost");

    c_take: cover property (take);
    c_nested_enable: cover property (isr_start_out ##[1:50] take);
    c_sw_post: cover property (clr_wr && swpost_reg);
    c_unmapped: cover property (pslverr_out);
endmodule : pic_irq_ctrl

// file: hdl/pic_pkg.sv
// Types shared by the interrupt controller modules
package pic_pkg;
    typedef enum logic [1:0] {
        pic_st_idle = 2'b00,
        pic_st_dispatch = 2'b01,
        pic_st_jump = 2'b10
    } pic_state_t;

    typedef struct packed {
        logic valid;
        logic [4:0] slot;
    } pic_sel_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pic_push_t;

    typedef struct packed {
        logic load;
        logic [15:0] value;
    } pic_pc_load_t;
endpackage : pic_pkg

// file: hdl/pic_prio_enc.sv
// Fixed-priority encoder, the lowest request index wins
module pic_prio_enc
    import pic_pkg::*;
#(
    parameter int N = 26
) (
    input wire logic [N-1:0] req_in,
    output pic_sel_t sel_out
);
    // Scan downward so the last hit is the lowest index
    always_comb begin
        sel_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                sel_out.valid = 1'b1;
                sel_out.slot = 5'(i);
            end
        end
    end
endmodule : pic_prio_enc
